// ==== include/charger_wled_pkg.sv ====
`default_nettype none
package charger_wled_pkg;

    // Register addresses
    localparam logic [7:0] ADDR_SETUP_TWO = 8'h05;
    localparam logic [7:0] ADDR_SETUP_THREE = 8'h06;
    localparam logic [7:0] ADDR_LED_ONE = 8'h07;
    localparam logic [7:0] ADDR_LED_DUTY = 8'h08;

    // Values after reset
    localparam logic [7:0] RST_SETUP_TWO = 8'h80;
    localparam logic [7:0] RST_SETUP_THREE = 8'hB6;
    localparam logic [7:0] RST_LED_ONE = 8'h01;
    localparam logic [7:0] RST_LED_DUTY = 8'h00;

    // Field positions, charger setup two
    localparam int SLOWDOWN_BIT = 7;
    localparam int PRECHG_THR_BIT = 6;
    localparam int VOLT_LSB = 4;
    // Field positions, charger setup three
    localparam int CURR_LSB = 6;
    localparam int PPATH_LSB = 4;
    localparam int PRECHG_TIME_BIT = 3;
    localparam int TERM_LSB = 1;
    localparam int TEMP_BIT = 0;
    // Field positions, LED control one
    localparam int SINK_BIT = 3;
    localparam int LEVEL_BIT = 2;
    localparam int FREQ_LSB = 0;
    localparam int DUTY_W = 7;

    // Duty codes at or above this give no light
    localparam logic [6:0] DUTY_OFF_MIN = 7'h64;
    localparam logic [6:0] PWM_LAST_SLOT = 7'h63;
    localparam int PWM_SLOTS = 100;

    // Dimming timing
    localparam int CLK_HZ = 125_000_000;
    localparam int FREQ0_HZ = 100;
    localparam int FREQ1_HZ = 200;
    localparam int FREQ2_HZ = 500;
    localparam int FREQ3_HZ = 1000;
    localparam int STEP0_CYC = CLK_HZ / (FREQ0_HZ * PWM_SLOTS);
    localparam int STEP1_CYC = CLK_HZ / (FREQ1_HZ * PWM_SLOTS);
    localparam int STEP2_CYC = CLK_HZ / (FREQ2_HZ * PWM_SLOTS);
    localparam int STEP3_CYC = CLK_HZ / (FREQ3_HZ * PWM_SLOTS);

    // Analog set points
    localparam logic [12:0] PRECHG_HI_MV = 13'd2900;
    localparam logic [12:0] PRECHG_LO_MV = 13'd2500;
    localparam logic [6:0] TEMP_NARROW_C = 7'd45;
    localparam logic [6:0] TEMP_WIDE_C = 7'd60;
    localparam logic [6:0] PRECHG_SHORT_MIN = 7'd30;
    localparam logic [6:0] PRECHG_LONG_MIN = 7'd60;

    function automatic logic [12:0] charge_mv(input logic [1:0] code);
        unique case (code)
            2'h0: charge_mv = 13'd4100;
            2'h1: charge_mv = 13'd4150;
            2'h2: charge_mv = 13'd4200;
            2'h3: charge_mv = 13'd4250;
        endcase
    endfunction : charge_mv

    function automatic logic [9:0] charge_ma(input logic [1:0] code);
        unique case (code)
            2'h0: charge_ma = 10'd300;
            2'h1: charge_ma = 10'd400;
            2'h2: charge_ma = 10'd500;
            2'h3: charge_ma = 10'd700;
        endcase
    endfunction : charge_ma

    function automatic logic [12:0] ppath_mv(input logic [1:0] code);
        unique case (code)
            2'h0: ppath_mv = 13'd3500;
            2'h1: ppath_mv = 13'd3750;
            2'h2: ppath_mv = 13'd4000;
            2'h3: ppath_mv = 13'd4250;
        endcase
    endfunction : ppath_mv

endpackage : charger_wled_pkg
`default_nettype wire

// ==== rtl/dimming_pwm.sv ====
`timescale 1ns/1ps
`default_nettype none
module dimming_pwm #(
    parameter int STEP0 = charger_wled_pkg::STEP0_CYC,
    parameter int STEP1 = charger_wled_pkg::STEP1_CYC,
    parameter int STEP2 = charger_wled_pkg::STEP2_CYC,
    parameter int STEP3 = charger_wled_pkg::STEP3_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic [1:0] dimming_frequency_code,
    input wire logic [6:0] duty_code,
    output logic pwm_q
);
    logic [15:0] step_cnt_q;
    logic [6:0] slot_q;
    wire logic [15:0] step_len;
    wire logic step_end;
    wire logic light_on;

    // Period is 100 slots, each slot step_len clocks long
    assign step_len = (dimming_frequency_code == 2'h0) ? 16'(STEP0) :
                      (dimming_frequency_code == 2'h1) ? 16'(STEP1) :
                      (dimming_frequency_code == 2'h2) ? 16'(STEP2) : 16'(STEP3);
    // Comparing with >= lets a frequency change mid-slot recover at once
    assign step_end = step_cnt_q >= (step_len - 16'h0001);
    assign light_on = (duty_code < charger_wled_pkg::DUTY_OFF_MIN) && (slot_q <= duty_code);

    always_ff @(posedge clk) begin
        if (rst || !enable) begin
            step_cnt_q <= 16'h0000;
            slot_q <= 7'h00;
            pwm_q <= 1'b0;
        end else begin
            step_cnt_q <= step_end ? 16'h0000 : step_cnt_q + 16'h0001;
            if (step_end) begin
                slot_q <= (slot_q == charger_wled_pkg::PWM_LAST_SLOT) ? 7'h00 : slot_q + 7'h01;
            end
            pwm_q <= light_on;
        end
    end

    AST_PWM_ZERO_DUTY: assert property (@(posedge clk) disable iff (rst)
        enable && $stable(duty_code) && duty_code >= charger_wled_pkg::DUTY_OFF_MIN
        |=> !pwm_q) else $error("pwm lit with zero-duty code");
    AST_PWM_FULL_DUTY: assert property (@(posedge clk) disable iff (rst)
        enable && $past(enable) && duty_code == 7'h63 && $past(duty_code) == 7'h63
        |=> pwm_q) else $error("pwm dark at full duty");
endmodule : dimming_pwm
`default_nettype wire

// ==== rtl/charger_wled_config_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module charger_wled_config_regs #(
    parameter int STEP0 = charger_wled_pkg::STEP0_CYC,
    parameter int STEP1 = charger_wled_pkg::STEP1_CYC,
    parameter int STEP2 = charger_wled_pkg::STEP2_CYC,
    parameter int STEP3 = charger_wled_pkg::STEP3_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata_q,
    output logic reg_rvalid_q,
    input wire logic safety_tick,
    input wire logic thermal_loop_active,
    input wire logic power_path_loop,
    output logic timer_tick_q,
    output logic [12:0] precharge_threshold_mv_q,
    output logic [12:0] charge_voltage_mv_q,
    output logic [9:0] charge_current_ma_q,
    output logic [12:0] power_path_threshold_mv_q,
    output logic [6:0] precharge_time_min_q,
    output logic [1:0] termination_factor_q,
    output logic [6:0] charge_temp_max_c_q,
    output logic [1:0] led_sinks_on_q,
    output logic led_level_select_q,
    output logic dimming_pwm_q
);
    logic [7:0] setup_two_q;
    logic [7:0] setup_three_q;
    logic [7:0] led_one_q;
    logic [6:0] led_duty_q;
    logic half_q;

    wire logic sel_two;
    wire logic sel_three;
    wire logic sel_led;
    wire logic sel_duty;
    wire logic [7:0] read_mux;
    wire logic slow;
    wire logic timer_slowdown_enable;
    wire logic precharge_threshold_select;
    wire logic [1:0] charge_voltage_code;
    wire logic [1:0] charge_current_code;
    wire logic [1:0] power_path_threshold_code;
    wire logic precharge_time_select;
    wire logic charge_temp_window;
    wire logic led_sink_enable;
    wire logic led_level_select;
    wire logic [1:0] dimming_frequency_code;

    assign sel_two = reg_addr == charger_wled_pkg::ADDR_SETUP_TWO;
    assign sel_three = reg_addr == charger_wled_pkg::ADDR_SETUP_THREE;
    assign sel_led = reg_addr == charger_wled_pkg::ADDR_LED_ONE;
    assign sel_duty = reg_addr == charger_wled_pkg::ADDR_LED_DUTY;
    // Unmapped addresses read as zero and swallow writes
    assign read_mux = sel_two ? setup_two_q :
                      sel_three ? setup_three_q :
                      sel_led ? led_one_q :
                      sel_duty ? {1'b0, led_duty_q} : 8'h00;

    assign timer_slowdown_enable = setup_two_q[charger_wled_pkg::SLOWDOWN_BIT];
    assign precharge_threshold_select = setup_two_q[charger_wled_pkg::PRECHG_THR_BIT];
    assign charge_voltage_code = setup_two_q[charger_wled_pkg::VOLT_LSB +: 2];
    assign charge_current_code = setup_three_q[charger_wled_pkg::CURR_LSB +: 2];
    assign power_path_threshold_code = setup_three_q[charger_wled_pkg::PPATH_LSB +: 2];
    assign precharge_time_select = setup_three_q[charger_wled_pkg::PRECHG_TIME_BIT];
    assign charge_temp_window = setup_three_q[charger_wled_pkg::TEMP_BIT];
    assign led_sink_enable = led_one_q[charger_wled_pkg::SINK_BIT];
    assign led_level_select = led_one_q[charger_wled_pkg::LEVEL_BIT];
    assign dimming_frequency_code = led_one_q[charger_wled_pkg::FREQ_LSB +: 2];
    assign slow = timer_slowdown_enable && (thermal_loop_active || power_path_loop);

    // Registers; reserved and unused bits store what is written since they are R/W, except duty bit 7, which is not stored and reads zero
    always_ff @(posedge clk) begin
        if (rst) begin
            setup_two_q <= charger_wled_pkg::RST_SETUP_TWO;
            setup_three_q <= charger_wled_pkg::RST_SETUP_THREE;
            led_one_q <= charger_wled_pkg::RST_LED_ONE;
            led_duty_q <= charger_wled_pkg::RST_LED_DUTY[6:0];
        end else if (reg_write) begin
            if (sel_two) setup_two_q <= reg_wdata;
            if (sel_three) setup_three_q <= reg_wdata;
            if (sel_led) led_one_q <= reg_wdata;
            if (sel_duty) led_duty_q <= reg_wdata[6:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata_q <= 8'h00;
            reg_rvalid_q <= 1'b0;
        end else begin
            reg_rdata_q <= reg_read ? read_mux : reg_rdata_q;
            reg_rvalid_q <= reg_read;
        end
    end

    // Timer slowdown drops every second tick; the phase holds while not slowed
    always_ff @(posedge clk) begin
        if (rst) begin
            half_q <= 1'b0;
            timer_tick_q <= 1'b0;
        end else begin
            if (safety_tick && slow) half_q <= !half_q;
            timer_tick_q <= safety_tick && (!slow || half_q);
        end
    end

    // Decoded set points lag the register by one clock
    always_ff @(posedge clk) begin
        if (rst) begin
            precharge_threshold_mv_q <= charger_wled_pkg::PRECHG_HI_MV;
            charge_voltage_mv_q <= charger_wled_pkg::charge_mv(2'h0);
            charge_current_ma_q <= charger_wled_pkg::charge_ma(2'h2);
            power_path_threshold_mv_q <= charger_wled_pkg::ppath_mv(2'h3);
            precharge_time_min_q <= charger_wled_pkg::PRECHG_SHORT_MIN;
            termination_factor_q <= charger_wled_pkg::RST_SETUP_THREE[charger_wled_pkg::TERM_LSB +: 2];
            charge_temp_max_c_q <= charger_wled_pkg::TEMP_NARROW_C;
            led_sinks_on_q <= 2'h0;
            led_level_select_q <= 1'b0;
        end else begin
            precharge_threshold_mv_q <= precharge_threshold_select ?
                charger_wled_pkg::PRECHG_LO_MV : charger_wled_pkg::PRECHG_HI_MV;
            charge_voltage_mv_q <= charger_wled_pkg::charge_mv(charge_voltage_code);
            charge_current_ma_q <= charger_wled_pkg::charge_ma(charge_current_code);
            power_path_threshold_mv_q <= charger_wled_pkg::ppath_mv(power_path_threshold_code);
            precharge_time_min_q <= precharge_time_select ?
                charger_wled_pkg::PRECHG_LONG_MIN : charger_wled_pkg::PRECHG_SHORT_MIN;
            // Passed through as stored; software is trusted not to change it
            termination_factor_q <= setup_three_q[charger_wled_pkg::TERM_LSB +: 2];
            charge_temp_max_c_q <= charge_temp_window ?
                charger_wled_pkg::TEMP_WIDE_C : charger_wled_pkg::TEMP_NARROW_C;
            led_sinks_on_q <= {2{led_sink_enable}};
            led_level_select_q <= led_level_select;
        end
    end

    dimming_pwm #(
        .STEP0(STEP0),
        .STEP1(STEP1),
        .STEP2(STEP2),
        .STEP3(STEP3)
    ) dimming_pwm_i (
        .clk(clk),
        .rst(rst),
        .enable(led_sink_enable),
        .dimming_frequency_code(dimming_frequency_code),
        .duty_code(led_duty_q),
        .pwm_q(dimming_pwm_q)
    );

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Of two slowed ticks in a row exactly one must reach the timers
    AST_TICK_NOMINAL: assert property (safety_tick && !slow |=> timer_tick_q)
        else $error("nominal tick lost");
    AST_TICK_HALVED: assert property (safety_tick && slow ##1 safety_tick && slow && timer_tick_q
        |=> !timer_tick_q)
        else $error("tick passed twice in a row while slowed");
    AST_TICK_NOT_LOST: assert property (safety_tick && slow ##1 !timer_tick_q && safety_tick && slow
        |=> timer_tick_q)
        else $error("slowed tick lost twice in a row");
    // Decoded set points are checked two edges after the write; threshold and temperature window one edge after the register bit, every cycle
    AST_PRECHG_THR: assert property (!$past(rst) |->
        precharge_threshold_mv_q == ($past(precharge_threshold_select) ? 13'd2500 : 13'd2900))
        else $error("precharge threshold mismatch");
    AST_PPATH_THR: assert property (reg_write && sel_three && reg_wdata[5:4] == 2'h1
        |=> ##1 power_path_threshold_mv_q == 13'd3750)
        else $error("power path threshold mismatch");
    AST_TEMP_WINDOW: assert property (!$past(rst) |->
        charge_temp_max_c_q == ($past(charge_temp_window) ? 7'd60 : 7'd45))
        else $error("temperature window mismatch");
    AST_SINKS_TOGETHER: assert property (reg_write && sel_led |=> ##1
        led_sinks_on_q == {2{$past(reg_wdata[3], 2)}})
        else $error("sinks not switched together");
    AST_LEVEL_SEL: assert property (reg_write && sel_led && !$past(reg_write) |=> ##1
        led_level_select_q == $past(reg_wdata[2], 2))
        else $error("level select not following register");
    AST_DIM_OFF: assert property (!led_sink_enable && !$past(led_sink_enable) |-> !dimming_pwm_q)
        else $error("dimming active with sinks off");
    AST_CHARGE_VOLT: assert property (reg_write && sel_two && reg_wdata[5:4] == 2'h3
        |=> ##1 charge_voltage_mv_q == 13'd4250)
        else $error("charge voltage mismatch");
    AST_CHARGE_CURR: assert property (reg_write && sel_three && reg_wdata[7:6] == 2'h3
        |=> ##1 charge_current_ma_q == 10'd700)
        else $error("charge current mismatch");
    AST_PRECHG_TIME: assert property (reg_write && sel_three && reg_wdata[3] |=> ##1
        precharge_time_min_q == 7'd60)
        else $error("precharge time mismatch");
    AST_TERM_KEPT: assert property (reg_write && sel_three |=> ##1
        termination_factor_q == $past(reg_wdata[2:1], 2))
        else $error("termination factor not as stored");
    // Register port timing
    AST_READ_ANSWER: assert property (!$past(rst) |-> reg_rvalid_q == $past(reg_read))
        else $error("read answer not one cycle after request");
    AST_RDATA_HOLD: assert property (!reg_read |=> $stable(reg_rdata_q))
        else $error("read data changed without a read");
    AST_UNMAPPED_READ: assert property (reg_read && !(sel_two || sel_three || sel_led || sel_duty)
        |=> reg_rdata_q == 8'h00)
        else $error("unmapped address read nonzero");
    AST_DUTY_TOP_BIT: assert property (reg_read && sel_duty |=> !reg_rdata_q[7])
        else $error("duty register top bit read as one");

    COV_SLOWED: cover property (safety_tick && slow ##1 timer_tick_q);
    COV_READBACK: cover property (reg_write && sel_duty ##2 reg_read && sel_duty ##1 reg_rvalid_q);
    COV_PWM_EDGE: cover property (led_sink_enable ##1 dimming_pwm_q ##1 !dimming_pwm_q);
    COV_TICK_BURST: cover property ((safety_tick && slow) [*4]);
endmodule : charger_wled_config_regs
`default_nettype wire

// ==== verification/host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic clk,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_write,
    output logic reg_read
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == charger_wled_pkg::ADDR_SETUP_TWO) v[3:0] = 4'h0;
        if (a == charger_wled_pkg::ADDR_SETUP_THREE) v[2:1] = 2'h3;
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        // Released lines show garbage, not the last value
        reg_addr <= ~a;
        reg_wdata <= ~v;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        reg_addr <= ~a;
    endtask : rd
endmodule : host_model
`default_nettype wire

// ==== verification/charger_wled_config_regs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module charger_wled_config_regs_tb;
    logic clk, rst, safety_tick, thermal_loop_active, power_path_loop, reg_write, reg_read;
    logic [7:0] reg_addr, reg_wdata, reg_rdata_q;
    logic reg_rvalid_q, timer_tick_q, led_level_select_q, dimming_pwm_q;
    logic [12:0] prechg_mv, volt_mv, ppath_mv;
    logic [9:0] curr_ma;
    logic [6:0] time_min, temp_c;
    logic [1:0] term_f, sinks;
    int fails = 0;
    int samples_checked = 0;
    int ticks = 0;
    logic [7:0] exp_q[$];
    int vt[4] = '{4100, 4150, 4200, 4250};
    int it[4] = '{300, 400, 500, 700};
    int pt[4] = '{3500, 3750, 4000, 4250};
    int st[4] = '{4, 3, 2, 1};
    int dt[6] = '{0, 99, 100, 1, 127, 50};

    host_model host_model_i (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read));
    charger_wled_config_regs #(.STEP0(4), .STEP1(3), .STEP2(2), .STEP3(1)) charger_wled_config_regs_i (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
        .safety_tick(safety_tick), .thermal_loop_active(thermal_loop_active),
        .power_path_loop(power_path_loop), .timer_tick_q(timer_tick_q),
        .precharge_threshold_mv_q(prechg_mv), .charge_voltage_mv_q(volt_mv),
        .charge_current_ma_q(curr_ma), .power_path_threshold_mv_q(ppath_mv),
        .precharge_time_min_q(time_min), .termination_factor_q(term_f), .charge_temp_max_c_q(temp_c),
        .led_sinks_on_q(sinks), .led_level_select_q(led_level_select_q), .dimming_pwm_q(dimming_pwm_q));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t rdata got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_rd

    task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host_model_i.rd(a);
    endtask : rd_exp

    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask : settle

    task automatic wrap_up();
        // A read answer that never came counts as a mismatch
        if (exp_q.size() != 0) fails++;
        $display("comparisons=%0d mismatches=%0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up

    // Read results arrive in request order
    always @(negedge clk) begin
        if (reg_rvalid_q === 1'b1) begin
            if (exp_q.size() == 0) cmp({8'h00, reg_rdata_q}, 16'hFFFF);
            else cmp_rd(reg_rdata_q, exp_q.pop_front());
        end
        if (timer_tick_q === 1'b1) ticks++;
    end

    initial begin
        repeat (50000) @(posedge clk);
        fails++;
        wrap_up();
    end

    initial begin
        int v, p, c, b, n, e;
        rst = 1'b1;
        safety_tick = 1'b0;
        thermal_loop_active = 1'b0;
        power_path_loop = 1'b0;
        void'($urandom(32'hA017BF99));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        #1;
        cmp(16'(prechg_mv), 16'd2900);
        cmp(16'(volt_mv), 16'd4100);
        cmp(16'(curr_ma), 16'd500);
        cmp(16'(ppath_mv), 16'd4250);
        cmp(16'(time_min), 16'd30);
        cmp(16'(term_f), 16'h0003);
        cmp(16'(temp_c), 16'd45);
        cmp(16'(sinks), 16'h0000);
        cmp(16'(led_level_select_q), 16'h0000);
        cmp(16'(dimming_pwm_q), 16'h0000);
        rd_exp(8'h05, charger_wled_pkg::RST_SETUP_TWO);
        rd_exp(8'h06, charger_wled_pkg::RST_SETUP_THREE);
        rd_exp(8'h07, charger_wled_pkg::RST_LED_ONE);
        rd_exp(8'h08, charger_wled_pkg::RST_LED_DUTY);
        rd_exp(8'h09, 8'h00);
        // Charger set points over every code, termination factor held at 3 by the host
        for (int i = 0; i < 8; i++) begin
            v = i % 4;
            p = 3 - v;
            c = (i < 4) ? v : $urandom % 4;
            b = i / 4;
            host_model_i.wr(8'h05, {1'b0, b[0], v[1:0], 4'h0});
            host_model_i.wr(8'h06, {c[1:0], p[1:0], b[0], 2'h3, b[0]});
            settle();
            cmp(16'(prechg_mv), b ? 16'd2500 : 16'd2900);
            cmp(16'(volt_mv), 16'(vt[v]));
            cmp(16'(curr_ma), 16'(it[c]));
            cmp(16'(ppath_mv), 16'(pt[p]));
            cmp(16'(time_min), b ? 16'd60 : 16'd30);
            cmp(16'(temp_c), b ? 16'd60 : 16'd45);
            cmp(16'(term_f), 16'h0003);
            rd_exp(8'h06, {c[1:0], p[1:0], b[0], 2'h3, b[0]});
        end
        for (int k = 0; k < 4; k++) begin
            host_model_i.wr(8'h07, {4'h0, k[1], k[0], 2'h0});
            settle();
            cmp(16'(sinks), {14'h0, {2{k[1]}}});
            cmp(16'(led_level_select_q), 16'(k[0]));
        end
        // Timer slowdown under each loop combination
        for (int m = 0; m < 8; m++) begin
            host_model_i.wr(8'h05, {m[2], 7'h00});
            thermal_loop_active <= m[0];
            power_path_loop <= m[1];
            settle();
            ticks = 0;
            // Back-to-back ticks exercise the drop-every-second path
            @(posedge clk);
            safety_tick <= 1'b1;
            repeat (6) @(posedge clk);
            safety_tick <= 1'b0;
            settle();
            cmp(16'(ticks), (m[2] && m[1:0] != 0) ? 16'd3 : 16'd6);
        end
        // Dimming high time per period, sinks off in the last case
        dt[3] = 1 + $urandom % 98;
        for (int f = 0; f < 6; f++) begin
            host_model_i.wr(8'h07, 8'h00);
            host_model_i.wr(8'h08, {1'b1, dt[f][6:0]});
            rd_exp(8'h08, {1'b0, dt[f][6:0]});
            host_model_i.wr(8'h07, {4'h0, f < 5, 1'b0, 2'(f % 4)});
            repeat (200 * st[f % 4]) @(posedge clk);
            n = 0;
            repeat (100 * st[f % 4]) @(negedge clk) n += dimming_pwm_q;
            e = (f < 5 && dt[f] < 100) ? (dt[f] + 1) * st[f % 4] : 0;
            cmp(16'(n), 16'(e));
        end
        // Reset again mid-run; stored settings must fall back
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        cmp(16'(ppath_mv), 16'd4250);
        rd_exp(8'h05, charger_wled_pkg::RST_SETUP_TWO);
        rd_exp(8'h06, charger_wled_pkg::RST_SETUP_THREE);
        settle();
        wrap_up();
    end
endmodule : charger_wled_config_regs_tb
`default_nettype wire
